//--- design/switch_irq_defines.vh
// Register indices, field positions and reset values of the switch interrupt enable block.
// Assumes a Wishbone slave with 32-bit data where byte address = 4 * register index.
`ifndef SWITCH_IRQ_DEFINES_VH
`define SWITCH_IRQ_DEFINES_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define EVT_EN_IDX        6'h24
`define EDGE_SEL_IDX      6'h25
`define EVT_PEND_IDX      6'h28
`define EDGE_PEND_IDX     6'h29
`define SW_LEVEL_IDX      6'h2A

// ****************************************************************
// Widths
// ****************************************************************
`define REG_W             24
`define EVT_N             12
`define SW_N              12

// ****************************************************************
// Event enable field positions
// ****************************************************************
`define BIT_CONVERTER_ERR 11
`define BIT_WETTING_ERR   10
`define BIT_SUPPLY_B      9
`define BIT_SUPPLY_A      8
`define BIT_CHECKSUM_DONE 7
`define BIT_UNDERVOLTAGE  6
`define BIT_OVERVOLTAGE   5
`define BIT_TEMP_WARNING  4
`define BIT_THERMAL_SHDN  3
`define BIT_SWITCH_CHANGE 2
`define BIT_PARITY_ERR    1
`define BIT_SERIAL_FAIL   0

// ****************************************************************
// Reset values and edge select codes
// ****************************************************************
`define EVT_EN_RESET      12'h000
`define EDGE_SEL_RESET    24'h00_0000
`define EDGE_NONE         2'h0
`define EDGE_RISE         2'h1
`define EDGE_FALL         2'h2
`define EDGE_BOTH         2'h3

`endif

//--- design/sticky_flags.v
// Bank of sticky pending flags: hardware sets, software clears with write-one.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module sticky_flags #(
	parameter WIDTH = 12
) (
	input  wire             core_clk,
	input  wire             sys_rst,
	input  wire [WIDTH-1:0] set_pulse,
	input  wire [WIDTH-1:0] clr_pulse,
	output reg  [WIDTH-1:0] flags_reg
);

	wire [WIDTH-1:0] flags_next;

	// Set wins over a clear in the same cycle
	assign flags_next = (flags_reg & ~clr_pulse) | set_pulse;

	// Flag storage
	always @(posedge core_clk) begin
		if (sys_rst) begin
			flags_reg <= {WIDTH{1'b0}};
		end else begin
			flags_reg <= flags_next;
		end
	end

endmodule

`default_nettype wire

//--- design/switch_crossing_detect.v
// Threshold crossing detector for switch inputs 0 to 11 with per-input edge select.
// Assumes comparator results are levels on core_clk, one bit per input.
`timescale 1ns/10ps
`default_nettype none
`include "switch_irq_defines.vh"

module switch_crossing_detect (
	input  wire                 core_clk,
	input  wire                 sys_rst,
	input  wire [`SW_N-1:0]     above_threshold,
	input  wire [2*`SW_N-1:0]   input_edge_select,
	output wire [`SW_N-1:0]     crossing_hit
);

	reg  [`SW_N-1:0] level_prev_reg;
	reg              armed_reg;

	// Remember last level; first sample after reset is not a crossing
	always @(posedge core_clk) begin
		if (sys_rst) begin
			level_prev_reg <= {`SW_N{1'b0}};
			armed_reg      <= 1'b0;
		end else begin
			level_prev_reg <= above_threshold;
			armed_reg      <= 1'b1;
		end
	end

	// Qualify each crossing with its 2-bit field at bits 2n+1:2n
	genvar n;
	generate
		for (n = 0; n < `SW_N; n = n + 1) begin : g_in
			wire [1:0] sel;
			wire       rise;
			wire       fall;
			assign sel  = input_edge_select[2*n+1:2*n];                // [RL15]
			assign rise = armed_reg & above_threshold[n] & ~level_prev_reg[n];
			assign fall = armed_reg & ~above_threshold[n] & level_prev_reg[n];
			assign crossing_hit[n] = (sel == `EDGE_RISE) ? rise :       // [RL17]
			                         (sel == `EDGE_FALL) ? fall :       // [RL18]
			                         (sel == `EDGE_BOTH) ? (rise | fall) : // [RL19]
			                         1'b0;                              // [RL16]
		end
	endgenerate

endmodule

`default_nettype wire

//--- design/switch_irq_enable.v
// Interrupt enable logic for a switch detection device, reached over classic Wishbone.
// Assumes event pulses and comparator levels come from logic on core_clk (40 MHz).
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "switch_irq_defines.vh"

// What this block does
// RL1 - Both enable registers reset to zero; event enable at 24h, edge select at 25h.
// RL2 - Event enable bits 23 to 12 read zero and ignore writes.
// RL3 - Bit 11 lets a converter error pull the interrupt low.
// RL4 - Bit 10 lets a wetting current error pull the interrupt low.
// RL5 - Bit 9 lets a second supply threshold crossing pull the interrupt low.
// RL6 - Bit 8 lets a first supply threshold crossing pull the interrupt low.
// RL7 - Bit 7 lets checksum completion pull the interrupt low.
// RL8 - Bit 6 lets an undervoltage event pull the interrupt low.
// RL9 - Bit 5 lets an overvoltage event pull the interrupt low.
// RL10 - Bit 4 lets a temperature warning pull the interrupt low.
// RL11 - Bit 3 lets a thermal shutdown pull the interrupt low.
// RL12 - Bit 2 lets a switch state change pull the interrupt low.
// RL13 - Bit 1 lets a parity failure pull the interrupt low.
// RL14 - Bit 0 lets a serial interface failure pull the interrupt low.
// RL15 - Input n has its 2-bit edge select at bits 2n+1:2n.
// RL16 - Edge select zero: the input never interrupts.
// RL17 - Edge select one: interrupt on rising threshold crossing only.
// RL18 - Edge select two: interrupt on falling threshold crossing only.
// RL19 - Edge select three: interrupt on both crossings.
// RL20 - Interrupt low while any enabled condition is pending, high otherwise.
module switch_irq_enable (
	input  wire              core_clk,
	input  wire              sys_rst,
	// Wishbone slave
	input  wire              wb_cyc_i,
	input  wire              wb_stb_i,
	input  wire              wb_we_i,
	input  wire [7:0]        wb_adr_i,
	input  wire [3:0]        wb_sel_i,
	input  wire [31:0]       wb_dat_i,
	output reg  [31:0]       wb_dat_o,
	output reg               wb_ack_o,
	// Event pulses from the device's detectors
	input  wire              converter_error,
	input  wire              wetting_error,
	input  wire              supply_threshold_b,
	input  wire              supply_threshold_a,
	input  wire              checksum_done,
	input  wire              undervoltage,
	input  wire              overvoltage,
	input  wire              temp_warning,
	input  wire              thermal_shutdown,
	input  wire              switch_state_change,
	input  wire              parity_error,
	input  wire              serial_fail,
	// Comparator results for switch inputs 0 to 11
	input  wire [`SW_N-1:0]  input_threshold_above,
	// Interrupt output, active low
	output reg               irq_n_reg
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	reg  [`EVT_N-1:0]    event_interrupt_enable_reg;
	reg  [`EVT_N-1:0]    event_interrupt_enable_next;
	reg  [`REG_W-1:0]    input_edge_interrupt_select_low_reg;
	reg  [`REG_W-1:0]    input_edge_interrupt_select_low_next;
	reg  [31:0]          rd_data;
	reg  [`EVT_N-1:0]    evt_clr;
	reg  [`SW_N-1:0]     edge_clr;
	wire                 access;
	wire                 wr_access;
	wire [5:0]           reg_idx;
	wire [`REG_W-1:0]    byte_mask;
	wire [`EVT_N-1:0]    evt_set;
	wire [`EVT_N-1:0]    evt_pend;
	wire [`EVT_N-1:0]    evt_gated;
	wire [`SW_N-1:0]     edge_hit;
	wire [`SW_N-1:0]     edge_pend;
	wire                 any_pending;

	// ****************************************************************
	// Bus decode
	// ****************************************************************

	// A request is served once; ack drops in the cycle after it is given
	assign access    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_access = access & wb_we_i;
	assign reg_idx   = wb_adr_i[7:2];

	// Byte enables for the three low lanes
	assign byte_mask = {{8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// ****************************************************************
	// Event inputs
	// ****************************************************************

	// Gather detector pulses into their enable bit positions
	assign evt_set[`BIT_CONVERTER_ERR] = converter_error;
	assign evt_set[`BIT_WETTING_ERR]   = wetting_error;
	assign evt_set[`BIT_SUPPLY_B]      = supply_threshold_b;
	assign evt_set[`BIT_SUPPLY_A]      = supply_threshold_a;
	assign evt_set[`BIT_CHECKSUM_DONE] = checksum_done;
	assign evt_set[`BIT_UNDERVOLTAGE]  = undervoltage;
	assign evt_set[`BIT_OVERVOLTAGE]   = overvoltage;
	assign evt_set[`BIT_TEMP_WARNING]  = temp_warning;
	assign evt_set[`BIT_THERMAL_SHDN]  = thermal_shutdown;
	assign evt_set[`BIT_SWITCH_CHANGE] = switch_state_change;
	assign evt_set[`BIT_PARITY_ERR]    = parity_error;
	assign evt_set[`BIT_SERIAL_FAIL]   = serial_fail;

	// ****************************************************************
	// Write path
	// ****************************************************************

	// Next values of the two enable registers under byte enables
	always @* begin
		event_interrupt_enable_next          = event_interrupt_enable_reg;
		input_edge_interrupt_select_low_next = input_edge_interrupt_select_low_reg;
		if (wr_access && reg_idx == `EVT_EN_IDX) begin
			// Only bits 11:0 are stored; upper bits are dropped [RL2]
			event_interrupt_enable_next =
				(event_interrupt_enable_reg & ~byte_mask[`EVT_N-1:0]) |
				(wb_dat_i[`EVT_N-1:0] & byte_mask[`EVT_N-1:0]);
		end
		if (wr_access && reg_idx == `EDGE_SEL_IDX) begin
			input_edge_interrupt_select_low_next =
				(input_edge_interrupt_select_low_reg & ~byte_mask) |
				(wb_dat_i[`REG_W-1:0] & byte_mask);
		end
	end

	// Write-one-to-clear strobes for the pending registers
	always @* begin
		evt_clr  = {`EVT_N{1'b0}};
		edge_clr = {`SW_N{1'b0}};
		if (wr_access && reg_idx == `EVT_PEND_IDX) begin
			evt_clr = wb_dat_i[`EVT_N-1:0] & byte_mask[`EVT_N-1:0];
		end
		if (wr_access && reg_idx == `EDGE_PEND_IDX) begin
			edge_clr = wb_dat_i[`SW_N-1:0] & byte_mask[`SW_N-1:0];
		end
	end

	// Enable registers start with every source disabled
	always @(posedge core_clk) begin
		if (sys_rst) begin
			event_interrupt_enable_reg          <= `EVT_EN_RESET;   // [RL1]
			input_edge_interrupt_select_low_reg <= `EDGE_SEL_RESET; // [RL1]
		end else begin
			event_interrupt_enable_reg          <= event_interrupt_enable_next;
			input_edge_interrupt_select_low_reg <= input_edge_interrupt_select_low_next;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************

	// Register read multiplexer; unmapped addresses read zero
	always @* begin
		rd_data = 32'h0000_0000;
		case (reg_idx)
			`EVT_EN_IDX: begin
				rd_data[`EVT_N-1:0] = event_interrupt_enable_reg; // [RL2]
			end
			`EDGE_SEL_IDX: begin
				rd_data[`REG_W-1:0] = input_edge_interrupt_select_low_reg;
			end
			`EVT_PEND_IDX: begin
				rd_data[`EVT_N-1:0] = evt_pend;
			end
			`EDGE_PEND_IDX: begin
				rd_data[`SW_N-1:0] = edge_pend;
			end
			`SW_LEVEL_IDX: begin
				rd_data[`SW_N-1:0] = input_threshold_above;
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end

	// Registered ack and read data, one cycle after the request
	always @(posedge core_clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= access;
			if (access && !wb_we_i) begin
				wb_dat_o <= rd_data;
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end

	// ****************************************************************
	// Pending events
	// ****************************************************************

	// Every event is latched; the enable decides whether it reaches the pin
	sticky_flags #(
		.WIDTH (`EVT_N)
	) u_evt_flags (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.set_pulse (evt_set),
		.clr_pulse (evt_clr),
		.flags_reg (evt_pend)
	);

	// Gate each pending event with its enable bit
	assign evt_gated[`BIT_CONVERTER_ERR] =
		evt_pend[`BIT_CONVERTER_ERR] & event_interrupt_enable_reg[`BIT_CONVERTER_ERR]; // [RL3]
	assign evt_gated[`BIT_WETTING_ERR] =
		evt_pend[`BIT_WETTING_ERR] & event_interrupt_enable_reg[`BIT_WETTING_ERR]; // [RL4]
	assign evt_gated[`BIT_SUPPLY_B] =
		evt_pend[`BIT_SUPPLY_B] & event_interrupt_enable_reg[`BIT_SUPPLY_B]; // [RL5]
	assign evt_gated[`BIT_SUPPLY_A] =
		evt_pend[`BIT_SUPPLY_A] & event_interrupt_enable_reg[`BIT_SUPPLY_A]; // [RL6]
	assign evt_gated[`BIT_CHECKSUM_DONE] =
		evt_pend[`BIT_CHECKSUM_DONE] & event_interrupt_enable_reg[`BIT_CHECKSUM_DONE]; // [RL7]
	assign evt_gated[`BIT_UNDERVOLTAGE] =
		evt_pend[`BIT_UNDERVOLTAGE] & event_interrupt_enable_reg[`BIT_UNDERVOLTAGE]; // [RL8]
	assign evt_gated[`BIT_OVERVOLTAGE] =
		evt_pend[`BIT_OVERVOLTAGE] & event_interrupt_enable_reg[`BIT_OVERVOLTAGE]; // [RL9]
	assign evt_gated[`BIT_TEMP_WARNING] =
		evt_pend[`BIT_TEMP_WARNING] & event_interrupt_enable_reg[`BIT_TEMP_WARNING]; // [RL10]
	assign evt_gated[`BIT_THERMAL_SHDN] =
		evt_pend[`BIT_THERMAL_SHDN] & event_interrupt_enable_reg[`BIT_THERMAL_SHDN]; // [RL11]
	assign evt_gated[`BIT_SWITCH_CHANGE] =
		evt_pend[`BIT_SWITCH_CHANGE] & event_interrupt_enable_reg[`BIT_SWITCH_CHANGE]; // [RL12]
	assign evt_gated[`BIT_PARITY_ERR] =
		evt_pend[`BIT_PARITY_ERR] & event_interrupt_enable_reg[`BIT_PARITY_ERR]; // [RL13]
	assign evt_gated[`BIT_SERIAL_FAIL] =
		evt_pend[`BIT_SERIAL_FAIL] & event_interrupt_enable_reg[`BIT_SERIAL_FAIL]; // [RL14]

	// ****************************************************************
	// Switch input crossings
	// ****************************************************************

	// Crossings already filtered by each input's edge select
	switch_crossing_detect u_cross (
		.core_clk          (core_clk),
		.sys_rst           (sys_rst),
		.above_threshold   (input_threshold_above),
		.input_edge_select (input_edge_interrupt_select_low_reg),
		.crossing_hit      (edge_hit)
	);

	// Selected crossings stay pending until software clears them
	sticky_flags #(
		.WIDTH (`SW_N)
	) u_edge_flags (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.set_pulse (edge_hit),
		.clr_pulse (edge_clr),
		.flags_reg (edge_pend)
	);

	// ****************************************************************
	// Interrupt output
	// ****************************************************************

	// Any enabled event or selected crossing still pending
	assign any_pending = (|evt_gated) | (|edge_pend);

	// Pin low while something enabled is pending, released otherwise
	always @(posedge core_clk) begin
		if (sys_rst) begin
			irq_n_reg <= 1'b1;
		end else begin
			irq_n_reg <= ~any_pending; // [RL20]
		end
	end

endmodule

`default_nettype wire

//--- verification/switch_irq_monitor.sv
// Checker for the switch interrupt enable block, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module switch_irq_checker (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [11:0] input_threshold_above,
	input wire logic        irq_n_reg,
	input wire logic        converter_error,
	input wire logic        wetting_error,
	input wire logic        supply_threshold_b,
	input wire logic        supply_threshold_a,
	input wire logic        checksum_done,
	input wire logic        undervoltage,
	input wire logic        overvoltage,
	input wire logic        temp_warning,
	input wire logic        thermal_shutdown,
	input wire logic        switch_state_change,
	input wire logic        parity_error,
	input wire logic        serial_fail
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Anything that may legally pull the interrupt low
	logic [11:0] thr_q;
	logic        trig;
	always @(posedge core_clk) begin
		thr_q <= input_threshold_above;
	end
	assign trig = converter_error | wetting_error | supply_threshold_b | supply_threshold_a
		| checksum_done | undervoltage | overvoltage | temp_warning | thermal_shutdown
		| switch_state_change | parity_error | serial_fail | (wb_ack_o & wb_we_i)
		| (input_threshold_above != thr_q);
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_rd_evt; s_req ##0 (!wb_we_i && wb_adr_i == 8'h90); endsequence
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_ack_resp; s_req |=> wb_ack_o; endproperty
	property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
	property p_rsv; s_rd_evt |=> wb_dat_o[31:12] == 20'h0_0000; endproperty
	property p_rst_rel; $fell(sys_rst) |-> irq_n_reg && !wb_ack_o; endproperty
	property p_irq_fall;
		$fell(irq_n_reg) |-> $past(trig) || $past(trig, 2) || $past(trig, 3);
	endproperty
	property p_irq_rise;
		$rose(irq_n_reg) |-> $past(sys_rst) || $past(wb_ack_o && wb_we_i);
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
	a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
	a_rst_rel: assert property (p_rst_rel) else $error("bad state after reset");
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt without cause");
	a_irq_rise: assert property (p_irq_rise) else $error("interrupt released alone");
endmodule
bind switch_irq_enable switch_irq_checker u_switch_irq_checker (.core_clk(core_clk),
	.sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_n_reg(irq_n_reg),
	.input_threshold_above(input_threshold_above), .converter_error(converter_error),
	.wetting_error(wetting_error), .supply_threshold_b(supply_threshold_b),
	.supply_threshold_a(supply_threshold_a), .checksum_done(checksum_done),
	.undervoltage(undervoltage), .overvoltage(overvoltage), .temp_warning(temp_warning),
	.thermal_shutdown(thermal_shutdown), .switch_state_change(switch_state_change),
	.parity_error(parity_error), .serial_fail(serial_fail));
`default_nettype wire

//--- verification/host_irq_watch.sv
// Host side model: counts every assertion of the interrupt line.
// Assumes the line is sampled on the device clock.
`timescale 1ns/10ps
`default_nettype none
module host_irq_watch (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic irq_n,
	output var int   falls
);
	logic last_q;
	// Count high to low changes of the line
	always @(posedge core_clk) begin
		if (sys_rst) begin
			falls <= 0;
			last_q <= 1'b1;
		end else begin
			last_q <= irq_n;
			if (last_q && !irq_n)
				falls <= falls + 1;
		end
	end
endmodule
`default_nettype wire

//--- verification/switch_irq_enable_bench.sv
// Self-checking bench for the switch interrupt enable block.
// Assumes Wishbone byte address = 4 * register index, pending flags write-one-to-clear.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module switch_irq_enable_bench;
	logic        core_clk = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0]  wb_adr_i = 0;
	logic [3:0]  wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, rd, r;
	logic        wb_ack_o, irq_n_reg, prev = 1;
	logic [11:0] evt = 0, thr = 0;
	int          fails = 0, cmp_count = 0, cyc_n = 0, falls, mdl_falls = 0;
	int          en = 0, pend = 0, epend = 0, sel, n;
	switch_irq_enable u_switch_irq_enable (.core_clk(core_clk), .sys_rst(sys_rst),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.converter_error(evt[11]), .wetting_error(evt[10]), .supply_threshold_b(evt[9]),
		.supply_threshold_a(evt[8]), .checksum_done(evt[7]), .undervoltage(evt[6]),
		.overvoltage(evt[5]), .temp_warning(evt[4]), .thermal_shutdown(evt[3]),
		.switch_state_change(evt[2]), .parity_error(evt[1]), .serial_fail(evt[0]),
		.input_threshold_above(thr), .irq_n_reg(irq_n_reg));
	host_irq_watch u_host_irq_watch (.core_clk(core_clk), .sys_rst(sys_rst),
		.irq_n(irq_n_reg), .falls(falls));
	// **********
	// Clock, timeout and shared tasks
	// **********
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			fails++;
			finish_test;
		end
	end
	task step(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge core_clk);
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		wb(0, a, 0);
		`CHK(rd, e)
	endtask
	// Expected line: low while any enabled event or any edge hit is pending
	task chk_irq;
		logic x;
		x = ((en & pend) | epend) == 0;
		if (prev && !x) mdl_falls++;
		prev = x;
		`CHK(irq_n_reg, x)
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// **********
	// Tests
	// **********
	initial begin
		void'($urandom(1542));
		step(20);
		sys_rst <= 0;
		step(1);
		rd_chk(8'h90, 0);
		rd_chk(8'h94, 0);
		wb(1, 8'hFC, 32'hFFFF_FFFF);
		rd_chk(8'hFC, 0);
		wb(1, 8'h90, 32'hFFFF_FFFF);
		rd_chk(8'h90, 32'h0000_0FFF);
		r = $urandom & 32'h00FF_FFFF;
		wb(1, 8'h94, r);
		rd_chk(8'h94, r);
		wb(1, 8'h94, 0);
		$display("test registers done");
		for (int i = 0; i < 12; i++) begin
			for (int k = 0; k < 2; k++) begin
				en = k ? (1 << i) : (12'hFFF ^ (1 << i));
				wb(1, 8'h90, en);
				evt[i] <= 1'b1;
				step(1);
				evt <= 0;
				pend = 1 << i;
				step(3);
				chk_irq;
				rd_chk(8'hA0, pend);
				wb(1, 8'hA0, pend);
				pend = 0;
				step(1);
				chk_irq;
			end
		end
		$display("test events done");
		for (int c = 0; c < 4; c++) begin
			n = $urandom_range(11, 0);
			sel = c << (2 * n);
			wb(1, 8'h94, sel);
			for (int v = 1; v >= 0; v--) begin
				thr[n] <= v[0];
				if (v ? c[0] : c[1]) epend |= 1 << n;
				step(3);
				rd_chk(8'hA4, epend);
				rd_chk(8'hA8, {20'h0_0000, thr});
				chk_irq;
			end
			wb(1, 8'hA4, 32'h0000_0FFF);
			epend = 0;
			step(1);
			chk_irq;
		end
		`CHK(falls, mdl_falls)
		$display("test edges done");
		finish_test;
	end
endmodule
`default_nettype wire
